// ---- logic/mwss_map.svh ----
/*
 * Holds the named constants of the word sync and squelch block.
 * Assumes it is included by bare name before any module uses it.
 */
`ifndef MWSS_MAP_SVH
`define MWSS_MAP_SVH

// ****************************************************
// Register byte addresses and field positions
// ****************************************************
`define MWSS_ADDR_W        12
`define MWSS_OFS_CTRL_A    12'h000
`define MWSS_OFS_SQUELCH   12'h004
`define MWSS_OFS_BYTE      12'h008
`define MWSS_BIT_CHAN      0
`define MWSS_BIT_REFRAME   1
`define MWSS_BIT_SYSTEM    2
`define MWSS_BIT_BUSY_IDLE 6
`define MWSS_CTRL_RESET    3'h0
`define MWSS_SQ_RESET      4'h0

// ****************************************************
// Squelch and sampling constants
// ****************************************************
`define MWSS_SQ_MAX        6'h3e
`define MWSS_NOM_10K       6'h32
`define MWSS_NOM_8K        6'h3f
`define MWSS_SAMPLE_KHZ    504

// ****************************************************
// Framing constants
// ****************************************************
`define MWSS_SYNC_WORD     11'h712
`define MWSS_BYTE_LAST     3'h7
`define MWSS_BI_LAST       4'ha
`define MWSS_FRAME_W       10
`define MWSS_FRAME_LAST    10'h1cf

`endif

// ---- logic/mwss_pkg.sv ----
/*
 * Holds the types shared by the word sync and squelch block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package mwss_pkg;

  // ****************************************************
  // Detector modes from channel type and reframe enable
  // ****************************************************
  typedef enum logic [1:0] {
    MWSS_CTRL_SYNC   = 2'b00,
    MWSS_CTRL_UNSYNC = 2'b01,
    MWSS_VOICE_FIX   = 2'b10,
    MWSS_VOICE_RFR   = 2'b11
  } mwss_mode_e;

  // One decided bit from the qualifier
  typedef struct packed {
    logic valid;
    logic value;
    logic approved;
  } mwss_bit_s;

  // APB request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mwss_apb_req_s;

endpackage

`default_nettype wire

// ---- logic/mwss_bit_qual.sv ----
/*
 * Holds the per-bit sample tally and squelch approval.
 * Assumes samp_tick pulses once per 504 kHz sample and bit_end
 * pulses once at the end of each regenerated bit period.
 */
`include "mwss_map.svh"
`default_nettype none

module mwss_bit_qual (
  input  wire logic              sys_clk,
  input  wire logic              rst_sync_b,
  input  wire logic              samp_tick,
  input  wire logic              samp_val,
  input  wire logic              bit_end,
  input  wire logic [3:0]        thresh_code,
  input  wire logic              sys_8k,
  output var  mwss_pkg::mwss_bit_s bit_out
);

  logic [5:0]          ones;
  logic [5:0]          zeros;
  logic [5:0]          next_ones;
  logic [5:0]          next_zeros;
  logic [5:0]          nominal;
  logic [5:0]          need;
  logic [5:0]          best;
  mwss_pkg::mwss_bit_s next_bit_out;

  // ****************************************************
  // Tally and decision
  // ****************************************************
  always_comb begin
    nominal = sys_8k ? `MWSS_NOM_8K : `MWSS_NOM_10K;
    need = `MWSS_SQ_MAX - {1'b0, thresh_code, 1'b0};
    best = (ones >= zeros) ? ones : zeros;
    next_ones = ones;
    next_zeros = zeros;
    next_bit_out = '0;
    if (bit_end) begin
      // Majority decides value, the majority count is checked
      next_bit_out.valid = 1'b1;
      next_bit_out.value = (ones >= zeros);
      next_bit_out.approved = (best >= need);
      next_ones = '0;
      next_zeros = '0;
    end else if (samp_tick && (6'(ones + zeros) < nominal)) begin
      if (samp_val) begin
        next_ones = 6'(ones + 6'h01);
      end else begin
        next_zeros = 6'(zeros + 6'h01);
      end
    end
  end

  // Registers of the tally
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ones <= '0;
      zeros <= '0;
      bit_out <= '0;
    end else begin
      ones <= next_ones;
      zeros <= next_zeros;
      bit_out <= next_bit_out;
    end
  end

endmodule

`default_nettype wire

// ---- logic/mwss_top.sv ----
/*
 * Holds the receive word sync detector, byte framer, squelch tally
 * and APB register file of the modem receiver.
 * Assumes an APB master on sys_clk, a 504 kHz sample strobe, a bit
 * end strobe and a tone update strobe from the modem timing logic.
 */
`include "mwss_map.svh"
`default_nettype none

// Function
// - Threshold code 0 needs 62 samples, each step two fewer, down to 32.
// - Nominal samples per bit are 50 at 10 kHz and 63 at 8 kHz.
// - At bit end, approve the bit if its correct samples meet threshold.
// - Shift bits through an 11-bit register and match the sync word.
// - Pulse the sync interrupt on every sync match in every mode.
// - With reframe enabled, a sync match realigns byte boundaries.
// - With reframe disabled, a sync match leaves byte alignment alone.
// - Pack bits into bytes, first received bit in the top bit.
// - Tally approved bits per byte as a 4-bit value 0 to 8.
// - Counters pulse the byte-ready interrupt when byte and tally load.
// - Hold the last busy/idle bit; pulse shared interrupt on each update.
// - Control synchronised: no reframe, busy/idle removed, shared irq used.
// - Control unsynchronised: reframe, busy/idle kept, shared irq invalid.
// - Voice: all bits delivered, shared irq marks tone updates.
// - All bits but extracted busy/idle reach the byte, sync included.
// - Load the approved-bit sum together with the data byte.
// - Samples are taken at the 504 kHz sample strobe.
// - In control synchronised mode, frame counters realign bytes every frame.
module mwss_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        samp_tick,
  input  wire logic        samp_val,
  input  wire logic        bit_end,
  input  wire logic        tone_update,
  output logic             sync_word_irq,
  output logic             byte_ready_irq,
  output logic             busy_idle_or_tone_irq
);

  // ****************************************************
  // Reset release
  // ****************************************************
  logic rst_meta_b;
  logic rst_sync_b;

  // Two flops release the asynchronous reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ****************************************************
  // APB register file
  // ****************************************************
  mwss_pkg::mwss_apb_req_s req;
  logic                    channel_type_sel;
  logic                    reframe_enable;
  logic                    sys_8k;
  logic [3:0]              squelch_threshold_sel;
  logic                    next_channel_type_sel;
  logic                    next_reframe_enable;
  logic                    next_sys_8k;
  logic [3:0]              next_squelch_threshold_sel;
  logic [31:0]             next_prdata;
  logic                    next_pslverr;
  logic                    acc;
  logic                    hit;
  logic [7:0]              rx_byte;
  logic [3:0]              approved_bit_count;
  logic                    busy_idle;
  logic                    ack;
  logic                    next_ack;

  // One wait state lets registered read data stand with pready
  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign acc = req.psel && req.penable;
  assign pready = ack;

  // Decode, write and read data of the three ports
  always_comb begin
    next_channel_type_sel = channel_type_sel;
    next_reframe_enable = reframe_enable;
    next_sys_8k = sys_8k;
    next_squelch_threshold_sel = squelch_threshold_sel;
    next_prdata = '0;
    next_pslverr = 1'b0;
    next_ack = acc && !ack;
    hit = 1'b1;
    unique case (req.paddr)
      `MWSS_OFS_CTRL_A: begin
        next_prdata[`MWSS_BIT_CHAN] = channel_type_sel;
        next_prdata[`MWSS_BIT_REFRAME] = reframe_enable;
        next_prdata[`MWSS_BIT_SYSTEM] = sys_8k;
      end
      `MWSS_OFS_SQUELCH: begin
        next_prdata[3:0] = approved_bit_count;
        next_prdata[`MWSS_BIT_BUSY_IDLE] = busy_idle;
      end
      `MWSS_OFS_BYTE: begin
        next_prdata[7:0] = rx_byte;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (acc && !req.pwrite && !ack) begin
      next_pslverr = !hit;
    end else begin
      next_prdata = prdata;
    end
    if (acc && req.pwrite && !ack) begin
      next_pslverr = !hit || (req.paddr == `MWSS_OFS_BYTE);
    end
    // Writes land at the edge where pready is high
    if (acc && req.pwrite && ack) begin
      if (req.paddr == `MWSS_OFS_CTRL_A) begin
        next_channel_type_sel = req.pwdata[`MWSS_BIT_CHAN];
        next_reframe_enable = req.pwdata[`MWSS_BIT_REFRAME];
        next_sys_8k = req.pwdata[`MWSS_BIT_SYSTEM];
      end
      if (req.paddr == `MWSS_OFS_SQUELCH) begin
        next_squelch_threshold_sel = req.pwdata[3:0];
      end
    end
  end

  // Registers of the bus slave
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      {sys_8k, reframe_enable, channel_type_sel} <= `MWSS_CTRL_RESET;
      squelch_threshold_sel <= `MWSS_SQ_RESET;
      prdata <= '0;
      pslverr <= 1'b0;
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
      channel_type_sel <= next_channel_type_sel;
      reframe_enable <= next_reframe_enable;
      sys_8k <= next_sys_8k;
      squelch_threshold_sel <= next_squelch_threshold_sel;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************
  // Bit qualifier
  // ****************************************************
  mwss_pkg::mwss_bit_s rx_bit;

  mwss_bit_qual u_qual (
    .sys_clk     (sys_clk),
    .rst_sync_b  (rst_sync_b),
    .samp_tick   (samp_tick),
    .samp_val    (samp_val),
    .bit_end     (bit_end),
    .thresh_code (squelch_threshold_sel),
    .sys_8k      (sys_8k),
    .bit_out     (rx_bit)
  );

  // ****************************************************
  // Word sync detector and byte framer
  // ****************************************************
  mwss_pkg::mwss_mode_e           mode;
  logic [10:0]                    sync_sr;
  logic [7:0]                     byte_sr;
  logic [2:0]                     bit_cnt;
  logic [3:0]                     tally;
  logic [3:0]                     bi_cnt;
  logic [`MWSS_FRAME_W-1:0]       frame_cnt;
  logic [10:0]                    next_sync_sr;
  logic [7:0]                     next_byte_sr;
  logic [2:0]                     next_bit_cnt;
  logic [3:0]                     next_tally;
  logic [3:0]                     next_bi_cnt;
  logic [`MWSS_FRAME_W-1:0]       next_frame_cnt;
  logic [7:0]                     next_rx_byte;
  logic [3:0]                     next_approved_bit_count;
  logic                           next_busy_idle;
  logic                           next_sync_word_irq;
  logic                           next_byte_ready_irq;
  logic                           next_busy_idle_or_tone_irq;
  logic                           sync_hit;
  logic                           do_reframe;
  logic                           frame_wrap;
  logic                           strip_bi;
  logic                           is_bi;

  assign mode = mwss_pkg::mwss_mode_e'({channel_type_sel, reframe_enable});
  assign next_sync_sr = {sync_sr[9:0], rx_bit.value};

  // Framing, busy/idle extraction, byte assembly and tally
  always_comb begin
    sync_hit = rx_bit.valid && (next_sync_sr == `MWSS_SYNC_WORD);
    frame_wrap = (frame_cnt == `MWSS_FRAME_LAST);
    strip_bi = 1'b0;
    do_reframe = 1'b0;
    unique case (mode)
      mwss_pkg::MWSS_CTRL_SYNC: begin
        strip_bi = 1'b1;
        do_reframe = rx_bit.valid && frame_wrap;
      end
      mwss_pkg::MWSS_CTRL_UNSYNC: begin
        do_reframe = sync_hit;
      end
      mwss_pkg::MWSS_VOICE_FIX: begin
        do_reframe = 1'b0;
      end
      mwss_pkg::MWSS_VOICE_RFR: begin
        do_reframe = sync_hit;
      end
    endcase
    is_bi = strip_bi && (bi_cnt == `MWSS_BI_LAST);
    next_byte_sr = byte_sr;
    next_bit_cnt = bit_cnt;
    next_tally = tally;
    next_bi_cnt = bi_cnt;
    next_frame_cnt = frame_cnt;
    next_rx_byte = rx_byte;
    next_approved_bit_count = approved_bit_count;
    next_busy_idle = busy_idle;
    next_sync_word_irq = sync_hit;
    next_byte_ready_irq = 1'b0;
    next_busy_idle_or_tone_irq = 1'b0;
    if (rx_bit.valid) begin
      next_frame_cnt = `MWSS_FRAME_W'(frame_cnt + 1'b1);
      next_bi_cnt = is_bi ? 4'h0 : 4'(bi_cnt + 4'h1);
      if (is_bi) begin
        // Extracted bit goes to the flag, not the byte
        next_busy_idle = rx_bit.value;
        next_busy_idle_or_tone_irq = 1'b1;
      end else begin
        next_byte_sr = {byte_sr[6:0], rx_bit.value};
        next_tally = 4'(tally + {3'h0, rx_bit.approved});
        next_bit_cnt = 3'(bit_cnt + 3'h1);
        if (bit_cnt == `MWSS_BYTE_LAST) begin
          // Byte and its tally load together
          next_rx_byte = next_byte_sr;
          next_approved_bit_count = next_tally;
          next_byte_ready_irq = 1'b1;
          next_tally = 4'h0;
        end
      end
      if (do_reframe) begin
        // Next bit starts a byte, a frame and a word
        next_bit_cnt = 3'h0;
        next_tally = 4'h0;
        next_byte_sr = 8'h00;
        next_frame_cnt = '0;
        next_bi_cnt = 4'h0;
      end
    end
    if (channel_type_sel) begin
      next_busy_idle_or_tone_irq = tone_update;
    end else if (reframe_enable) begin
      next_busy_idle_or_tone_irq = 1'b0;
    end
  end

  // Registers of the framer
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sync_sr <= '0;
      byte_sr <= '0;
      bit_cnt <= '0;
      tally <= '0;
      bi_cnt <= '0;
      frame_cnt <= '0;
      rx_byte <= '0;
      approved_bit_count <= '0;
      busy_idle <= 1'b0;
      sync_word_irq <= 1'b0;
      byte_ready_irq <= 1'b0;
      busy_idle_or_tone_irq <= 1'b0;
    end else begin
      if (rx_bit.valid) begin
        sync_sr <= next_sync_sr;
      end
      byte_sr <= next_byte_sr;
      bit_cnt <= next_bit_cnt;
      tally <= next_tally;
      bi_cnt <= next_bi_cnt;
      frame_cnt <= next_frame_cnt;
      rx_byte <= next_rx_byte;
      approved_bit_count <= next_approved_bit_count;
      busy_idle <= next_busy_idle;
      sync_word_irq <= next_sync_word_irq;
      byte_ready_irq <= next_byte_ready_irq;
      busy_idle_or_tone_irq <= next_busy_idle_or_tone_irq;
    end
  end

endmodule

`default_nettype wire

// ---- verification/mwss_top_chk.sv ----
/*
 * Port checker for the word sync and squelch block.
 * Assumes it is bound to mwss_top with every port by name.
 */
`default_nettype none

module mwss_top_chk (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        samp_tick,
  input wire logic        samp_val,
  input wire logic        bit_end,
  input wire logic        tone_update,
  input wire logic        sync_word_irq,
  input wire logic        byte_ready_irq,
  input wire logic        busy_idle_or_tone_irq
);
  // ****************************************************
  // Helpers: mode bits written, bits since last byte
  // ****************************************************
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  logic [3:0] nbits;
  logic [3:0] next_nbits;

  // Next mode copy and bit count
  always_comb begin
    next_ctrl = ctrl;
    next_nbits = nbits;
    if (psel && penable && pwrite && paddr == 12'h000) begin
      next_ctrl = pwdata[1:0];
    end
    if (bit_end && nbits != 4'hf) begin
      next_nbits = nbits + 4'h1;
    end
    if (byte_ready_irq) begin
      next_nbits = {3'h0, bit_end};
    end
  end

  // Registers of the helpers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= 2'h0;
      nbits <= 4'h0;
    end else begin
      ctrl <= next_ctrl;
      nbits <= next_nbits;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ****************************************************
  // Assertions
  // ****************************************************
  sequence s_rd_tally;
    psel && penable && !pwrite && paddr == 12'h004;
  endsequence
  sequence s_bad_acc;
    psel && penable && (paddr > 12'h008 || (pwrite && paddr == 12'h008));
  endsequence

  chk_sync_timing: assert property (sync_word_irq |-> $past(bit_end, 2))
    else $error("sync pulse without a bit end two cycles before");
  chk_sync_pulse: assert property (sync_word_irq |=> !sync_word_irq)
    else $error("sync pulse longer than one cycle");
  chk_byte_timing: assert property (byte_ready_irq |-> $past(bit_end, 2))
    else $error("byte pulse without a bit end two cycles before");
  chk_byte_bits: assert property (byte_ready_irq |-> nbits >= 4'h8)
    else $error("byte pulse after fewer than eight bits");
  chk_tally_range: assert property (s_rd_tally ##0 pready |-> prdata[3:0] <= 4'h8)
    else $error("tally read above eight");
  chk_tone_irq: assert property (ctrl[0] && tone_update |=> busy_idle_or_tone_irq)
    else $error("tone update without shared pulse");
  chk_shared_src: assert property (busy_idle_or_tone_irq |->
      $past(tone_update) || $past(bit_end, 2))
    else $error("shared pulse without a cause");
  chk_unsync_quiet: assert property (ctrl == 2'b10 && $past(ctrl, 2) == 2'b10
      |-> !busy_idle_or_tone_irq)
    else $error("shared pulse in unsynchronised control mode");
  chk_bad_access: assert property (s_bad_acc ##0 pready |-> pslverr)
    else $error("bad access not refused");
  chk_ready_wait: assert property (pready |->
      psel && penable && $past(psel && penable))
    else $error("ready outside a waited access phase");
endmodule

`default_nettype wire

// ---- verification/mwss_dec_model.sv ----
/*
 * Model of the upstream data decoder: sample strobes and bit ends.
 * Assumes the bench calls send_bit once the block is out of reset.
 */
`default_nettype none

module mwss_dec_model (
  input  wire logic sys_clk,
  output var  logic samp_tick,
  output var  logic samp_val,
  output var  logic bit_end
);
  initial begin
    samp_tick = 1'b0;
    samp_val = 1'b0;
    bit_end = 1'b0;
  end

  // One bit: k samples agree with b, the rest disagree; 50 per bit
  task automatic send_bit(input logic b, input int k);
    for (int i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      samp_tick <= 1'b1;
      samp_val <= (i < k) ? b : ~b;
      @(posedge sys_clk);
      samp_tick <= 1'b0;
      samp_val <= ~samp_val; // Idle line shows no stale value
    end
    @(posedge sys_clk);
    bit_end <= 1'b1;
    @(posedge sys_clk);
    bit_end <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule

`default_nettype wire

// ---- verification/mwss_top_tb.sv ----
/*
 * Self-checking bench of the word sync and squelch block.
 * Assumes the design files, the decoder model and the checker.
 */
`include "mwss_map.svh"
`default_nettype none

module mwss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        tone_update = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        samp_tick;
  logic        samp_val;
  logic        bit_end;
  logic        sync_word_irq;
  logic        byte_ready_irq;
  logic        busy_idle_or_tone_irq;
  int          err_count = 0;
  int          samples_checked = 0;
  int          n_sync = 0;
  int          n_byte = 0;
  int          n_sh = 0;

  mwss_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .samp_tick(samp_tick), .samp_val(samp_val), .bit_end(bit_end),
    .tone_update(tone_update), .sync_word_irq(sync_word_irq),
    .byte_ready_irq(byte_ready_irq),
    .busy_idle_or_tone_irq(busy_idle_or_tone_irq));
  mwss_dec_model dec (.sys_clk(sys_clk), .samp_tick(samp_tick),
    .samp_val(samp_val), .bit_end(bit_end));

  // Clock of 5 ns and pulse counters
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (sync_word_irq === 1'b1) n_sync++;
    if (byte_ready_irq === 1'b1) n_byte++;
    if (busy_idle_or_tone_irq === 1'b1) n_sh++;
  end

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // APB access; read data and error taken at the ready edge
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] xd,
                     input logic xe);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    if (!w) chk(prdata, xd);
    chk({31'h0, pslverr}, {31'h0, xe});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) dec.send_bit(v[i], 50);
  endtask

  task automatic tone;
    @(posedge sys_clk);
    tone_update <= 1'b1;
    @(posedge sys_clk);
    tone_update <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_regs;
    acc(0, 12'h000, 0, 32'h0, 0);
    acc(0, 12'h004, 0, 32'h0, 0);
    acc(0, 12'h008, 0, 32'h0, 0);
    acc(1, 12'h000, 32'h7, 0, 0);
    acc(0, 12'h000, 0, 32'h7, 0);
    acc(1, 12'h00c, 32'h1, 0, 1);
    acc(1, 12'h008, 32'hff, 0, 1);
    acc(0, 12'h008, 0, 32'h0, 0);
  endtask

  task automatic t_voice;
    int s0 = n_sync;
    int b0 = n_byte;
    int h0;
    logic [7:0] v = 8'ha5;
    acc(1, 12'h000, 32'h3, 0, 0);
    acc(1, 12'h004, 32'hf, 0, 0);
    send(16'h2, 2);
    send(`MWSS_SYNC_WORD, 11);
    for (int i = 7; i >= 0; i--) dec.send_bit(v[i], i % 2 ? 32 : 31);
    acc(0, 12'h008, 0, 32'ha5, 0);
    acc(0, 12'h004, 0, 32'h4, 0);
    chk(n_byte - b0, 2);
    chk(n_sync - s0, 1);
    h0 = n_sh;
    tone();
    chk(n_sh - h0, 1);
  endtask

  task automatic t_fix;
    int s0 = n_sync;
    acc(1, 12'h000, 32'h1, 0, 0);
    send(16'hbc, 8);
    acc(0, 12'h008, 0, 32'hbc, 0);
    send(16'h49, 8);
    acc(0, 12'h008, 0, 32'h49, 0);
    chk(n_sync - s0, 1);
  endtask

  task automatic t_ctrl;
    int h0;
    acc(1, 12'h000, 32'h2, 0, 0);
    acc(1, 12'h004, 32'h6, 0, 0);
    send(`MWSS_SYNC_WORD, 11);
    h0 = n_sh;
    tone();
    chk(n_sh - h0, 0);
    acc(1, 12'h000, 32'h0, 0, 0);
    send(16'h3c, 8);
    acc(0, 12'h008, 0, 32'h3c, 0);
    send(16'h1, 2);
    send(16'h1, 1);
    send(16'h1a, 6);
    acc(0, 12'h008, 0, 32'h5a, 0);
    acc(0, 12'h004, 0, 32'h48, 0);
    chk(n_sh - h0, 1);
  endtask

  // ****************************************************
  // Verdict, main sequence and watchdog
  // ****************************************************
  task automatic close_out;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_voice();
    t_fix();
    t_ctrl();
    close_out();
  end

  initial begin
    #300000;
    err_count++;
    close_out();
  end
endmodule

bind mwss_top mwss_top_chk chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .samp_tick(samp_tick), .samp_val(samp_val), .bit_end(bit_end),
  .tone_update(tone_update), .sync_word_irq(sync_word_irq),
  .byte_ready_irq(byte_ready_irq),
  .busy_idle_or_tone_irq(busy_idle_or_tone_irq));

`default_nettype wire
